/* File: hdl/msp3_map.svh */
// Register map, field positions and reset values of the page 3 bank
// Functional notes
// - Writing 0x0003 to register 31 maps registers 16-30 onto page 3
// - Registers 0-15 stay in standard space whatever page is selected
// - Writing 0x0000 to register 31 restores main space for 16-30
// - Bit 15 set: disable MAC-side interface while media link is down
// - Bit 14 set: restart MAC-side interface on each media link change
// - Bit 13 set: parallel detect enabled during MAC-side negotiation
// - Writing 1 to bit 12 restarts negotiation; bit clears itself
// - Bit 11 set: advertise the advertised-ability word, not internal one
// - Advertised-ability reads current word; writes only while forced
// - Preamble 001: add one 0x55 when first two nibbles are not 0x5
// - Preamble 010: as 001, plus second 0x55 if next nibbles not 0x5
// - Preamble 000 leaves packets unchanged; 011-111 are reserved
// - Bit 7 set enables auto-negotiation on the serial MAC link
// - Bit 6 inverts receive polarity, bit 5 inverts transmit polarity
// - Status bit 11 reads 1 once partner requested negotiation restart
// - Status 9:8 give partner remote fault; 00 means no fault
// - Status 7:4 give partner asym pause, sym pause, full, half duplex
// - Status 3:0: partner capable, link up, negotiation done, signal
// - Partner-ability register holds last word received from partner
// - Serial status bit 14 latches signal detect, clears when read
`ifndef MSP3_MAP_SVH
`define MSP3_MAP_SVH
`define MSP3_IDX_CTRL 5'h10
`define MSP3_IDX_STAT 5'h11
`define MSP3_IDX_ADV 5'h12
`define MSP3_IDX_LPA 5'h13
`define MSP3_IDX_SER 5'h14
`define MSP3_IDX_PAGE 5'h1F
`define MSP3_IDX_HIGH 5'h10
`define MSP3_PAGE_MAIN 16'h0000
`define MSP3_PAGE_P3 16'h0003
`define MSP3_B_DIS 15
`define MSP3_B_RST 14
`define MSP3_B_PD 13
`define MSP3_B_ANRS 12
`define MSP3_B_FRC 11
`define MSP3_F_PRE_HI 10
`define MSP3_F_PRE_LO 8
`define MSP3_B_ANEN 7
`define MSP3_B_RXI 6
`define MSP3_B_TXI 5
`define MSP3_B_LPRS 11
`define MSP3_B_SDET 14
`define MSP3_B_SYNC 13
`define MSP3_LP_RF_HI 13
`define MSP3_LP_RF_LO 12
`define MSP3_LP_ASYM 8
`define MSP3_LP_SYM 7
`define MSP3_LP_HD 6
`define MSP3_LP_FD 5
`define MSP3_PRE_RST 3'h1
`define MSP3_ADV_RST 16'h0000
`define MSP3_NIB_PRE 4'h5
`endif

/* File: hdl/msp3_pkg.sv */
// Types shared by the page 3 register bank
package msp3_pkg;
  typedef enum logic [2:0] {
    MSP3_PRE_NONE = 3'h0,
    MSP3_PRE_ONE = 3'h1,
    MSP3_PRE_TWO = 3'h2
  } msp3_pre_t;
  typedef enum logic {
    MSP3_BUS_IDLE,
    MSP3_BUS_ACK
  } msp3_bus_t;
endpackage : msp3_pkg

/* File: hdl/msp3_regs.sv */
// Page 3 register bank of the MAC-side serial link, Wishbone slave
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/100ps
`include "msp3_map.svh"
module msp3_regs #(
  parameter int AW = 7,
  parameter int DW = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DW-1:0] wb_dat_i,
  output logic [DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic media_link_up_i,
  input wire logic [15:0] int_cfg_word_i,
  input wire logic lp_word_vld_i,
  input wire logic [15:0] lp_word_i,
  input wire logic lp_restart_req_i,
  input wire logic mac_link_up_i,
  input wire logic an_complete_i,
  input wire logic sig_detect_i,
  input wire logic sync_i,
  input wire logic pkt_start_i,
  input wire logic [15:0] pkt_nibbles_i,
  output logic if_disable_o,
  output logic if_restart_o,
  output logic parallel_detect_en_o,
  output logic an_restart_o,
  output logic an_en_o,
  output logic rx_invert_o,
  output logic tx_invert_o,
  output logic [15:0] tx_cfg_word_o,
  output logic pad_vld_o,
  output logic [1:0] pad_count_o
);
  import msp3_pkg::*;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  msp3_bus_t bus_ff;
  logic [15:0] page_ff;
  logic req;
  logic wr;
  logic rd;
  logic [4:0] idx;
  logic lo_lane;
  logic hi_lane;

  function automatic logic on_p3(input logic [4:0] i,
                                 input logic [15:0] pg);
    on_p3 = (i >= `MSP3_IDX_HIGH) && (i != `MSP3_IDX_PAGE) &&
            (pg == `MSP3_PAGE_P3);
  endfunction : on_p3

  assign req = wb_cyc_i && wb_stb_i && (bus_ff == MSP3_BUS_IDLE);
  assign idx = wb_adr_i[6:2];
  assign wr = req && wb_we_i;
  assign rd = req && !wb_we_i;
  assign lo_lane = wb_sel_i[0];
  assign hi_lane = wb_sel_i[1];

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] dat,
                                        input logic lo,
                                        input logic hi);
    merge = {hi ? dat[15:8] : old[15:8], lo ? dat[7:0] : old[7:0]};
  endfunction : merge

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_ff <= MSP3_BUS_IDLE;
    end else begin
      unique case (bus_ff)
        MSP3_BUS_IDLE: begin
          if (req) begin
            bus_ff <= MSP3_BUS_ACK;
          end
        end
        MSP3_BUS_ACK: begin
          bus_ff <= MSP3_BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // ------------------------------------------------------------
  // Page select
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_ff <= `MSP3_PAGE_MAIN;
    end else if (wr && idx == `MSP3_IDX_PAGE) begin
      page_ff <= merge(page_ff, wb_dat_i[15:0], lo_lane, hi_lane);
    end
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  logic [15:0] ctrl_ff;
  logic [15:0] ctrl_wr;
  logic ctrl_hit;
  logic adv_hit;
  logic [15:0] adv_ff;
  logic force_adv;
  logic [2:0] pre_mode;

  assign ctrl_hit = wr && on_p3(idx, page_ff) && idx == `MSP3_IDX_CTRL;
  assign adv_hit = wr && on_p3(idx, page_ff) && idx == `MSP3_IDX_ADV;
  assign ctrl_wr = merge(ctrl_ff, wb_dat_i[15:0], lo_lane, hi_lane);
  assign force_adv = ctrl_ff[`MSP3_B_FRC];
  assign pre_mode = ctrl_ff[`MSP3_F_PRE_HI:`MSP3_F_PRE_LO];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= {5'h00, `MSP3_PRE_RST, 8'h00};
    end else if (ctrl_hit) begin
      ctrl_ff <= {ctrl_wr[15:5], 5'h00};
    end else begin
      ctrl_ff[`MSP3_B_ANRS] <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Advertised ability
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adv_ff <= `MSP3_ADV_RST;
    end else if (adv_hit && force_adv) begin
      adv_ff <= merge(adv_ff, wb_dat_i[15:0], lo_lane, hi_lane);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_cfg_word_o <= `MSP3_ADV_RST;
    end else begin
      tx_cfg_word_o <= force_adv ? adv_ff : int_cfg_word_i;
    end
  end

  // ------------------------------------------------------------
  // Link control outputs
  // ------------------------------------------------------------
  logic media_prev_ff;

  // Tracks the pin through reset too, so no false change follows reset
  always_ff @(posedge clk_i) begin
    media_prev_ff <= media_link_up_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      if_disable_o <= 1'b0;
      if_restart_o <= 1'b0;
    end else begin
      if_disable_o <= ctrl_ff[`MSP3_B_DIS] && !media_link_up_i;
      if_restart_o <= ctrl_ff[`MSP3_B_RST] &&
                      (media_prev_ff != media_link_up_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      parallel_detect_en_o <= 1'b0;
      an_restart_o <= 1'b0;
      an_en_o <= 1'b0;
      rx_invert_o <= 1'b0;
      tx_invert_o <= 1'b0;
    end else begin
      parallel_detect_en_o <= ctrl_ff[`MSP3_B_PD];
      an_restart_o <= ctrl_ff[`MSP3_B_ANRS];
      an_en_o <= ctrl_ff[`MSP3_B_ANEN];
      rx_invert_o <= ctrl_ff[`MSP3_B_RXI];
      tx_invert_o <= ctrl_ff[`MSP3_B_TXI];
    end
  end

  // ------------------------------------------------------------
  // Preamble padding for 10/100 packets
  // ------------------------------------------------------------
  logic first_ok;
  logic next_ok;

  assign first_ok = pkt_nibbles_i[15:12] == `MSP3_NIB_PRE ||
                    pkt_nibbles_i[11:8] == `MSP3_NIB_PRE;
  assign next_ok = pkt_nibbles_i[7:4] == `MSP3_NIB_PRE ||
                   pkt_nibbles_i[3:0] == `MSP3_NIB_PRE;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_vld_o <= 1'b0;
      pad_count_o <= 2'h0;
    end else begin
      pad_vld_o <= pkt_start_i;
      if (!pkt_start_i || first_ok) begin
        pad_count_o <= 2'h0;
      end else if (pre_mode == MSP3_PRE_ONE) begin
        pad_count_o <= 2'h1;
      end else if (pre_mode == MSP3_PRE_TWO) begin
        pad_count_o <= next_ok ? 2'h1 : 2'h2;
      end else begin
        pad_count_o <= 2'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // Partner status
  // ------------------------------------------------------------
  logic [15:0] lpa_ff;
  logic lp_capable_ff;
  logic lp_restart_ff;
  logic sdet_ff;
  logic rd_stat;
  logic rd_ser;

  assign rd_stat = rd && on_p3(idx, page_ff) && idx == `MSP3_IDX_STAT;
  assign rd_ser = rd && on_p3(idx, page_ff) && idx == `MSP3_IDX_SER;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lpa_ff <= 16'h0000;
      lp_capable_ff <= 1'b0;
    end else if (lp_word_vld_i) begin
      lpa_ff <= lp_word_i;
      lp_capable_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lp_restart_ff <= 1'b0;
    end else if (lp_restart_req_i) begin
      lp_restart_ff <= 1'b1;
    end else if (rd_stat) begin
      lp_restart_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdet_ff <= 1'b0;
    end else if (sig_detect_i) begin
      sdet_ff <= 1'b1;
    end else if (rd_ser) begin
      sdet_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [15:0] rd_word;

  always_comb begin
    rd_word = 16'h0000;
    if (idx == `MSP3_IDX_PAGE) begin
      rd_word = page_ff;
    end else if (on_p3(idx, page_ff)) begin
      unique case (idx)
        `MSP3_IDX_CTRL: rd_word = ctrl_ff;
        `MSP3_IDX_STAT: begin
          rd_word[`MSP3_B_LPRS] = lp_restart_ff;
          rd_word[9:8] = lpa_ff[`MSP3_LP_RF_HI:`MSP3_LP_RF_LO];
          rd_word[7] = lpa_ff[`MSP3_LP_ASYM];
          rd_word[6] = lpa_ff[`MSP3_LP_SYM];
          rd_word[5] = lpa_ff[`MSP3_LP_FD];
          rd_word[4] = lpa_ff[`MSP3_LP_HD];
          rd_word[3] = lp_capable_ff;
          rd_word[2] = mac_link_up_i;
          rd_word[1] = an_complete_i;
          rd_word[0] = sig_detect_i;
        end
        `MSP3_IDX_ADV: rd_word = tx_cfg_word_o;
        `MSP3_IDX_LPA: rd_word = lpa_ff;
        `MSP3_IDX_SER: begin
          rd_word[`MSP3_B_SDET] = sdet_ff;
          rd_word[`MSP3_B_SYNC] = sync_i;
        end
        default: rd_word = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (rd) begin
      wb_dat_o <= {{(DW-16){1'b0}}, rd_word};
    end
  end
endmodule : msp3_regs

/* File: tb/msp3_mac_model.sv */
// Behavioural MAC partner sending configuration words
`timescale 1ns/100ps
module msp3_mac_model (
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic [15:0] word_i,
  output logic lp_word_vld_o,
  output logic [15:0] lp_word_o
);
  initial lp_word_vld_o = 1'b0;
  initial lp_word_o = 16'h0000;
  // Word is valid for one cycle, then the bus scrambles
  always @(posedge clk_i) begin
    lp_word_vld_o <= send_i;
    lp_word_o <= send_i ? word_i : ~lp_word_o;
  end
endmodule : msp3_mac_model

/* File: tb/msp3_regs_props.sv */
// Port-level checks of the page 3 register bank
`timescale 1ns/100ps
module msp3_regs_props #(
  parameter int AW = 7,
  parameter int DW = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic media_link_up_i,
  input wire logic pkt_start_i,
  input wire logic [15:0] pkt_nibbles_i,
  input wire logic if_disable_o,
  input wire logic if_restart_o,
  input wire logic an_restart_o,
  input wire logic pad_vld_o,
  input wire logic [1:0] pad_count_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_next: assert property (s_req |=> s_ack)
    else $error("ack not one cycle after request");
  chk_dis_media: assert property (if_disable_o |-> !$past(media_link_up_i))
    else $error("disable while media was up");
  chk_rst_cause: assert property (if_restart_o |->
    $past(media_link_up_i) != $past(media_link_up_i, 2))
    else $error("restart without media change");
  chk_rst_pulse: assert property (if_restart_o |=> !if_restart_o)
    else $error("interface restart longer than a cycle");
  chk_anr_pulse: assert property (an_restart_o |=> !an_restart_o)
    else $error("negotiation restart longer than a cycle");
  chk_pad_when: assert property (pad_vld_o |-> $past(pkt_start_i))
    else $error("pad result without packet start");
  chk_pad_idle: assert property (!pad_vld_o |-> pad_count_o == 2'h0)
    else $error("pad count set while not valid");
  chk_pad_one: assert property (pad_vld_o && pad_count_o != 2'h0 |->
    $past(pkt_nibbles_i[15:12]) != 4'h5 &&
    $past(pkt_nibbles_i[11:8]) != 4'h5)
    else $error("pad added before a 0x5 nibble");
  chk_pad_two: assert property (pad_vld_o && pad_count_o == 2'h2 |->
    $past(pkt_nibbles_i[7:4]) != 4'h5 &&
    $past(pkt_nibbles_i[3:0]) != 4'h5)
    else $error("second pad despite a 0x5 nibble");
endmodule : msp3_regs_props
bind msp3_regs msp3_regs_props #(.AW(AW), .DW(DW)) chk_u (.*);

/* File: tb/mac_serdes_pcs_page3_regs_tb.sv */
// Self-checking bench for the page 3 register bank
`timescale 1ns/100ps
module mac_serdes_pcs_page3_regs_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, send;
  logic [6:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic media_link_up_i, lp_word_vld_i, lp_restart_req_i, mac_link_up_i;
  logic an_complete_i, sig_detect_i, sync_i, pkt_start_i, pad_vld_o;
  logic [15:0] int_cfg_word_i, lp_word_i, pkt_nibbles_i, tx_cfg_word_o;
  logic [15:0] word, rd;
  logic if_disable_o, if_restart_o, parallel_detect_en_o, an_restart_o;
  logic an_en_o, rx_invert_o, tx_invert_o;
  logic [1:0] pad_count_o;
  int miscompares, check_count, ifr_cnt, anr_cnt;
  msp3_regs dut_u (.*);
  msp3_mac_model mac_u (.clk_i(clk_i), .send_i(send), .word_i(word),
    .lp_word_vld_o(lp_word_vld_i), .lp_word_o(lp_word_i));
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (if_restart_o === 1'b1) ifr_cnt++;
    if (an_restart_o === 1'b1) anr_cnt++;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Classic cycle held until ack is sampled
  task wb(input logic we, input logic [4:0] idx, input logic [15:0] d);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'h3, we, idx, 2'h0};
    wb_dat_i <= {16'h0000, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: no ack seen %h expected %h", $time, 1'b0, 1'b1);
    end
    rd = wb_dat_o[15:0];
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask : wb
  task wr(input logic [4:0] idx, input logic [15:0] d);
    wb(1'b1, idx, d);
  endtask : wr
  task rc(input logic [4:0] idx, input logic [15:0] e);
    wb(1'b0, idx, 16'h0000);
    chk(rd, e);
  endtask : rc
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task t_page;
    rc(5'h10, 16'h0000);
    wr(5'h1F, 16'h0003);
    rc(5'h10, 16'h0100);
    wr(5'h05, 16'hFFFF);
    rc(5'h05, 16'h0000);
    rc(5'h15, 16'h0000);
    wr(5'h1F, 16'h0004);
    rc(5'h10, 16'h0000);
    wr(5'h1F, 16'h0000);
    rc(5'h10, 16'h0000);
    wr(5'h1F, 16'h0003);
    $display("t_page done");
  endtask : t_page
  task t_ctrl;
    wr(5'h10, 16'hF0FF);
    rc(5'h10, 16'hE0E0);
    chk(anr_cnt, 1);
    chk({parallel_detect_en_o, an_en_o, rx_invert_o, tx_invert_o}, 4'hF);
    wr(5'h10, 16'h2040);
    rc(5'h10, 16'h2040);
    chk({parallel_detect_en_o, an_en_o, rx_invert_o, tx_invert_o}, 4'hA);
    $display("t_ctrl done");
  endtask : t_ctrl
  task t_media;
    wr(5'h10, 16'hC100);
    @(posedge clk_i) media_link_up_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 chk(if_disable_o, 1'b1);
    @(posedge clk_i) media_link_up_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk(if_disable_o, 1'b0);
    chk(ifr_cnt, 2);
    $display("t_media done");
  endtask : t_media
  task t_adv;
    wr(5'h10, 16'h0100);
    wr(5'h12, 16'h1234);
    rc(5'h12, 16'h4321);
    chk(tx_cfg_word_o, 16'h4321);
    wr(5'h10, 16'h0900);
    rc(5'h12, 16'h0000);
    wr(5'h12, 16'h1234);
    rc(5'h12, 16'h1234);
    chk(tx_cfg_word_o, 16'h1234);
    $display("t_adv done");
  endtask : t_adv
  task t_partner;
    @(posedge clk_i) {sig_detect_i, mac_link_up_i, an_complete_i} <= 3'h7;
    word <= 16'h21A0;
    {send, lp_restart_req_i} <= 2'h3;
    @(posedge clk_i) {send, lp_restart_req_i} <= 2'h0;
    rc(5'h11, 16'h0AEF);
    rc(5'h11, 16'h02EF);
    rc(5'h13, 16'h21A0);
    @(posedge clk_i) {sync_i, sig_detect_i} <= 2'h2;
    rc(5'h14, 16'h6000);
    rc(5'h14, 16'h2000);
    $display("t_partner done");
  endtask : t_partner
  task pad(input logic [23:0] t);
    wr(5'h10, {5'h00, t[22:20], 8'h00});
    @(posedge clk_i) {pkt_start_i, pkt_nibbles_i} <= {1'b1, t[19:4]};
    @(posedge clk_i) pkt_start_i <= 1'b0;
    #1 chk({pad_vld_o, pad_count_o}, {1'b1, t[1:0]});
  endtask : pad
  task t_pad;
    logic [23:0] tab [6];
    tab = '{24'h1AAAA1, 24'h15AAA0, 24'h1A5AA0, 24'h2AAAA2, 24'h2AA5A1,
      24'h0AAAA0};
    for (int i = 0; i < 6; i++) pad(tab[i]);
    $display("t_pad done");
  endtask : t_pad
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    {clk_i, rst_i, media_link_up_i} = 3'h3;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'h3;
    int_cfg_word_i = 16'h4321;
    {lp_restart_req_i, mac_link_up_i, an_complete_i, sig_detect_i} = 4'h0;
    {sync_i, pkt_start_i, send, pkt_nibbles_i, word} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_page;
    t_ctrl;
    t_media;
    t_adv;
    t_partner;
    t_pad;
    tally_and_finish;
  end
  initial begin
    #400000;
    miscompares++;
    tally_and_finish;
  end
endmodule : mac_serdes_pcs_page3_regs_tb
